// ===== sram_cycle_pkg.sv
// shared constants and types for the synchronous burst sram cycle control
// assumes one clock domain; imported whole by every design module
//
// What this block does
// - processor strobe with chip selected starts read
// - writes only after controller start or burst continuation
// - write when global write, or gate plus lane
// - controller strobe plus write starts write burst
// - read start needs all selects, else deselect
// - both strobes high, step low: advance counter
// - both strobes high, step high: hold address
// - primary select high ignores processor strobe
// - data drive combines cycle type, output enable
// - write cycles mask output enable internally
// - read drives all bits only with enable low
// - gate low writes each selected lane plus parity
// - global write writes all lanes, overrides others
// - processor strobe low with primary select low ignores controller strobe
// - order select picks linear or interleaved sequence
// - sleep request snoozes after two cycles, tristated
package sram_cycle_pkg;

  // wide variant: four lanes of nine bits, 18-bit word address
  localparam int WIDE_LANES = 4;
  localparam int WIDE_ADDR_WIDTH = 18;
  // narrow variant: two lanes of nine bits, 19-bit word address
  localparam int NARROW_LANES = 2;
  localparam int NARROW_ADDR_WIDTH = 19;
  // one lane is eight data bits plus one parity bit
  localparam int LANE_BITS = 9;
  // burst counter covers the two low address bits
  localparam int BURST_BITS = 2;
  localparam logic [1:0] BURST_FIRST = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;
  // snooze entry and exit time, in clock periods
  localparam int SNOOZE_PERIODS = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SNOOZE_NS = SNOOZE_PERIODS * CLK_PERIOD_NS;
  localparam logic [1:0] SNOOZE_CYCLES = 2'(SNOOZE_NS / CLK_PERIOD_NS);

  // cycle type latched at each edge
  typedef enum logic [1:0] {CYC_DESEL, CYC_READ, CYC_WRITE} cycle_type;
  // power state around the sleep request
  typedef enum logic [1:0] {PWR_RUN, PWR_ENTER, PWR_SNOOZE, PWR_WAKE} power_type;

endpackage : sram_cycle_pkg

// ===== burst_if.sv
// carrier between the cycle decoder and the burst counter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface burst_if;
  logic load; // take a new start address
  logic step; // move to the next burst address
  logic [1:0] start_low; // low address bits at load
  logic order_interleaved; // high selects interleaved order
  logic [1:0] addr_low; // current low address bits

  modport decoder (output load, output step, output start_low, output order_interleaved,
                   input addr_low);
  modport counter (input load, input step, input start_low, input order_interleaved,
                   output addr_low);
endinterface : burst_if

// ===== burst_counter.sv
// two-bit wraparound burst counter, linear or interleaved order
// assumes load and step come from logic on the same clock
`timescale 1ns/1ps
module burst_counter
  import sram_cycle_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clk_en, // freezes all state while low
  burst_if.counter bus // load, step and current address
);

  logic [1:0] start_ff; // first address of the burst
  logic [1:0] count_ff; // steps taken since the start
  logic [1:0] low_ff; // address presented to the core
  logic [1:0] nxt_count; // count after one more step
  logic [1:0] nxt_low; // address after one more step

  // interleaved order xors the step count into the start, linear adds it
  assign nxt_count = count_ff + BURST_ONE;
  assign nxt_low = bus.order_interleaved ? (start_ff ^ nxt_count)
                                         : (start_ff + nxt_count);
  assign bus.addr_low = low_ff;

  // load wins over step; holding is simply neither
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_ff <= BURST_FIRST;
      count_ff <= BURST_FIRST;
      low_ff <= BURST_FIRST;
    end else if (clk_en) begin
      if (bus.load) begin
        start_ff <= bus.start_low;
        count_ff <= BURST_FIRST;
        low_ff <= bus.start_low;
      end else if (bus.step) begin
        count_ff <= nxt_count;
        low_ff <= nxt_low;
      end
    end
  end

  // interleaved step lands on the xor of start and count
  inter_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && bus.step && !bus.load && bus.order_interleaved
    |=> low_ff == ($past(start_ff) ^ $past(nxt_count)))
    else $error("interleaved step wrong");

endmodule : burst_counter

// ===== sram_cycle_ctrl.sv
// cycle control of a synchronous flow-through burst sram
// assumes bus inputs are synchronous to clk; sleep and order pins are not,
// output enable is asynchronous and only ever gates the data drive
`timescale 1ns/1ps
module sram_cycle_ctrl
  import sram_cycle_pkg::*;
#(
  parameter int LANES = WIDE_LANES,
  parameter int ADDR_WIDTH = WIDE_ADDR_WIDTH
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clk_en, // freezes all state while low
  input wire logic chip_select_primary_n, // primary select, low active
  input wire logic chip_select_depth_high, // depth select, high active
  input wire logic chip_select_depth_low_n, // depth select, low active
  input wire logic processor_address_strobe_n, // processor strobe
  input wire logic controller_address_strobe_n, // controller strobe
  input wire logic burst_step_n, // advance the burst when low
  input wire logic global_write_n, // write all lanes when low
  input wire logic byte_write_gate_n, // qualifies lane selects
  input wire logic [LANES-1:0] byte_lane_select_n, // per-lane write select
  input wire logic burst_order_sel, // high interleaved, low linear
  input wire logic sleep_request, // asynchronous snooze request
  input wire logic output_enable_n, // asynchronous output enable
  input wire logic [ADDR_WIDTH-1:0] addr_in, // external word address
  input wire logic [LANES*LANE_BITS-1:0] dq_in, // data lines, input side
  input wire logic [LANES*LANE_BITS-1:0] core_rdata, // core read data
  output logic [LANES*LANE_BITS-1:0] dq_out, // data lines, output side
  output logic dq_oe, // data lines driven when high
  output logic [ADDR_WIDTH-1:0] core_addr, // address used this cycle
  output logic [LANES-1:0] core_lane_we, // lanes written this edge
  output logic [LANES*LANE_BITS-1:0] core_wdata, // write data to the core
  output logic snoozing // device in snooze, high active
);

  // synchronisers for the two pins from outside the clock domain
  logic sleep_meta_ff; // first stage, read only by the second
  logic sleep_sync_ff; // synchronised sleep request
  logic order_meta_ff; // first stage, read only by the second
  logic order_sync_ff; // synchronised burst order select

  // cycle state
  cycle_type cycle_ff; // type of the cycle begun at the last edge
  cycle_type nxt_cycle; // type chosen at the coming edge
  power_type power_ff; // snooze state
  power_type nxt_power; // next snooze state
  logic [1:0] pwr_cnt_ff; // cycles spent entering or waking
  logic [1:0] nxt_pwr_cnt; // next value of the above
  logic burst_live_ff; // a burst is in progress
  logic [ADDR_WIDTH-1:0] addr_hi_ff; // upper address bits of the burst
  logic [LANES-1:0] lane_we_ff; // lane write strobes
  logic [LANES*LANE_BITS-1:0] wdata_ff; // captured write data
  logic snooze_ff; // registered snooze flag

  burst_if bif ();

  burst_counter u_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bus(bif.counter)
  );

  // decode of the sampled control inputs
  wire running = (power_ff == PWR_RUN) && !sleep_sync_ff;
  wire sel_all = !chip_select_primary_n && chip_select_depth_high
                 && !chip_select_depth_low_n;
  // processor strobe only counts while the primary select is low
  wire processor_address_strobe_n_go = !processor_address_strobe_n && !chip_select_primary_n;
  // controller strobe is ignored under a live processor strobe
  wire controller_address_strobe_n_go = !controller_address_strobe_n && !processor_address_strobe_n_go;
  wire any_lane = !(&byte_lane_select_n);
  wire write_ind = !global_write_n || (!byte_write_gate_n && any_lane);
  wire [LANES-1:0] lane_sel = global_write_n
                              ? ({LANES{!byte_write_gate_n}} & ~byte_lane_select_n)
                              : {LANES{1'b1}};
  wire start_burst = running && (processor_address_strobe_n_go || controller_address_strobe_n_go) && sel_all;
  wire carry_on = running && !processor_address_strobe_n_go && !controller_address_strobe_n_go && burst_live_ff;
  wire do_write = (controller_address_strobe_n_go && start_burst && write_ind) || (carry_on && write_ind);

  assign bif.load = clk_en && start_burst;
  assign bif.step = clk_en && carry_on && !burst_step_n;
  assign bif.start_low = addr_in[1:0];
  assign bif.order_interleaved = order_sync_ff;

  // choose the cycle type for the coming edge
  always_comb begin
    nxt_cycle = CYC_DESEL;
    if (!running) begin
      nxt_cycle = CYC_DESEL; // snooze: every input ignored
    end else if (processor_address_strobe_n_go) begin
      nxt_cycle = sel_all ? CYC_READ : CYC_DESEL;
    end else if (controller_address_strobe_n_go) begin
      if (!sel_all) begin
        nxt_cycle = CYC_DESEL;
      end else begin
        nxt_cycle = write_ind ? CYC_WRITE : CYC_READ;
      end
    end else if (burst_live_ff) begin
      nxt_cycle = write_ind ? CYC_WRITE : CYC_READ;
    end
  end

  // snooze sequencing: two cycles in, two cycles out
  always_comb begin
    nxt_power = power_ff;
    nxt_pwr_cnt = pwr_cnt_ff;
    case (power_ff)
      PWR_RUN: begin
        if (sleep_sync_ff) begin
          nxt_power = PWR_ENTER;
          nxt_pwr_cnt = 2'h1;
        end
      end
      PWR_ENTER: begin
        if (pwr_cnt_ff >= SNOOZE_CYCLES) begin
          nxt_power = PWR_SNOOZE;
        end else begin
          nxt_pwr_cnt = pwr_cnt_ff + 2'h1;
        end
      end
      PWR_SNOOZE: begin
        if (!sleep_sync_ff) begin
          nxt_power = PWR_WAKE;
          nxt_pwr_cnt = 2'h1;
        end
      end
      PWR_WAKE: begin
        if (pwr_cnt_ff >= SNOOZE_CYCLES) begin
          nxt_power = PWR_RUN;
        end else begin
          nxt_pwr_cnt = pwr_cnt_ff + 2'h1;
        end
      end
      default: begin
        nxt_power = PWR_RUN;
        nxt_pwr_cnt = 2'h0;
      end
    endcase
  end

  // two-flop synchronisers; sleep and order are never read at stage one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleep_meta_ff <= 1'b0;
      sleep_sync_ff <= 1'b0;
      order_meta_ff <= 1'b1;
      order_sync_ff <= 1'b1;
    end else if (clk_en) begin
      sleep_meta_ff <= sleep_request;
      sleep_sync_ff <= sleep_meta_ff;
      order_meta_ff <= burst_order_sel;
      order_sync_ff <= order_meta_ff;
    end
  end

  // power state and snooze flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_ff <= PWR_RUN;
      pwr_cnt_ff <= 2'h0;
      snooze_ff <= 1'b0;
    end else if (clk_en) begin
      power_ff <= nxt_power;
      pwr_cnt_ff <= nxt_pwr_cnt;
      snooze_ff <= (nxt_power != PWR_RUN);
    end
  end

  // cycle type and burst bookkeeping; a pending access dies at snooze entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycle_ff <= CYC_DESEL;
      burst_live_ff <= 1'b0;
    end else if (clk_en) begin
      cycle_ff <= nxt_cycle;
      burst_live_ff <= (nxt_cycle != CYC_DESEL);
    end
  end

  // address capture and write strobes to the core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_hi_ff <= '0;
      lane_we_ff <= '0;
      wdata_ff <= '0;
    end else if (clk_en) begin
      if (start_burst) begin
        addr_hi_ff <= addr_in;
      end
      lane_we_ff <= do_write ? lane_sel : '0;
      if (do_write) begin
        wdata_ff <= dq_in;
      end
    end
  end

  // the counter supplies the two low address bits
  assign core_addr = {addr_hi_ff[ADDR_WIDTH-1:BURST_BITS], bif.addr_low};
  assign core_lane_we = lane_we_ff;
  assign core_wdata = wdata_ff;
  assign snoozing = snooze_ff;
  // flow-through: core data goes straight out; output enable is never
  // registered so it stays a pure gate, at the cost of a combinational path
  assign dq_out = core_rdata;
  assign dq_oe = (cycle_ff == CYC_READ) && !output_enable_n && !snooze_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // processor start never writes, whatever the write inputs say
  processor_address_strobe_n_read_a: assert property (
    clk_en && running && processor_address_strobe_n_go && sel_all |=> cycle_ff == CYC_READ && lane_we_ff == '0)
    else $error("processor start did not begin a read");
  // write strobes only follow a non-processor start or a continuation
  write_source_a: assert property (
    clk_en && running && processor_address_strobe_n_go |=> lane_we_ff == '0)
    else $error("write strobe on a processor start edge");
  // closed write gate gives a read when global write is off
  write_ind_a: assert property (
    clk_en && running && controller_address_strobe_n_go && sel_all && global_write_n && byte_write_gate_n
    |=> cycle_ff == CYC_READ)
    else $error("closed write gate did not give a read");
  // controller start with write loads the external address
  controller_address_strobe_n_write_a: assert property (
    clk_en && running && controller_address_strobe_n_go && sel_all && write_ind
    |=> cycle_ff == CYC_WRITE && core_addr == $past(addr_in))
    else $error("controller write start wrong");
  // partial selects deselect
  desel_a: assert property (
    clk_en && running && (processor_address_strobe_n_go || controller_address_strobe_n_go) && !sel_all
    |=> cycle_ff == CYC_DESEL && !dq_oe)
    else $error("partial select did not deselect");
  // suspend keeps the burst address
  suspend_hold_a: assert property (
    clk_en && carry_on && burst_step_n |=> $stable(core_addr))
    else $error("suspend moved the address");
  // advance changes the low bits
  step_move_a: assert property (
    clk_en && carry_on && !burst_step_n |=> core_addr[1:0] != $past(core_addr[1:0]))
    else $error("advance kept the address");
  // writes never drive the data lines
  write_mask_a: assert property (
    cycle_ff == CYC_WRITE |-> !dq_oe)
    else $error("data lines driven in a write");
  // read drive is exactly the output enable
  read_drive_a: assert property (
    cycle_ff == CYC_READ && !snooze_ff |-> dq_oe == !output_enable_n)
    else $error("read drive does not follow output enable");
  // global write lands on every lane
  global_all_a: assert property (
    clk_en && do_write && !global_write_n |=> &lane_we_ff)
    else $error("global write missed a lane");
  // snooze reached two cycles after entry begins
  snooze_entry_a: assert property (
    clk_en && power_ff == PWR_RUN && sleep_sync_ff ##1 clk_en [*2]
    |-> ##1 power_ff == PWR_SNOOZE)
    else $error("snooze not reached in two cycles");

  read_burst_c: cover property (processor_address_strobe_n_go && sel_all && running ##1 carry_on [*3]);
  write_burst_c: cover property (controller_address_strobe_n_go && sel_all && write_ind && running
    ##1 (carry_on && write_ind) [*3]);
  snooze_c: cover property (power_ff == PWR_SNOOZE ##[1:20] power_ff == PWR_RUN);

endmodule : sram_cycle_ctrl

// ===== core_array_model.sv
// core array model behind the cycle control's core ports
// assumes the lane mask is a one-cycle pulse taken at the next edge
`timescale 1ns/1ps
module core_array_model
  import sram_cycle_pkg::*;
#(
  parameter int LANES = WIDE_LANES // lanes per word
) (
  input wire logic clk, // system clock
  input wire logic [3:0] addr_low, // low word address bits
  input wire logic [LANES-1:0] lane_we, // lanes written at the edge
  input wire logic [LANES*LANE_BITS-1:0] wdata, // write word
  output logic [LANES*LANE_BITS-1:0] rdata // flow-through read word
);
  // small array aliased on the low bits, enough to see lane effects
  logic [LANES*LANE_BITS-1:0] mem [16];
  // combinational read keeps the data flow-through
  assign rdata = mem[addr_low];
  // clear at start so unwritten words read as zero, not unknown
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = '0;
  end
  // each selected lane takes its data and parity bits together
  always @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) mem[addr_low][i*LANE_BITS +: LANE_BITS] <= wdata[i*LANE_BITS +: LANE_BITS];
    end
  end
endmodule : core_array_model

// ===== tb_sync_burst_sram_cycle_control.sv
// self-checking bench for the burst sram cycle control, wide variant
// assumes the core array model answers reads combinationally
`timescale 1ns/1ps
module tb_sync_burst_sram_cycle_control;
  import sram_cycle_pkg::*;
  localparam int W = WIDE_LANES * LANE_BITS; // word width
  logic clk, sys_rst, clk_en; // clock, reset, enable held high except for one three-tick frozen stretch
  logic chip_select_primary_n, chip_select_depth_high, chip_select_depth_low_n; // selects
  logic processor_address_strobe_n, controller_address_strobe_n, burst_step_n; // burst
  logic global_write_n, byte_write_gate_n; // write controls
  logic [WIDE_LANES-1:0] byte_lane_select_n, core_lane_we; // lane selects and mask
  logic burst_order_sel, sleep_request, output_enable_n; // slow and async pins
  logic [WIDE_ADDR_WIDTH-1:0] addr_in, core_addr; // external and used address
  logic [W-1:0] dq_in, core_rdata, dq_out, core_wdata; // data words
  logic dq_oe, snoozing; // drive enable and power state
  int failures = 0; // mismatches
  int tests_run = 0; // comparisons
  int cyc = 0; // model cycle: 0 deselect, 1 read, 2 write
  logic [WIDE_ADDR_WIDTH-1:0] base; // model start address
  logic [1:0] n; // model step count, wraps like the counter
  logic [W-1:0] mm [16]; // model memory, aliased like the core model
  bit asleep = 0; // model ignores the bus while set

  sram_cycle_ctrl i_sram_cycle_ctrl (.clk, .sys_rst, .clk_en, .chip_select_primary_n,
    .chip_select_depth_high, .chip_select_depth_low_n, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_step_n, .global_write_n, .byte_write_gate_n,
    .byte_lane_select_n, .burst_order_sel, .sleep_request, .output_enable_n, .addr_in,
    .dq_in, .core_rdata, .dq_out, .dq_oe, .core_addr, .core_lane_we, .core_wdata, .snoozing);
  core_array_model i_core_array_model (.clk, .addr_low(core_addr[3:0]),
    .lane_we(core_lane_we), .wdata(core_wdata), .rdata(core_rdata));

  // free-running 100 MHz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // one compare for every kind of result; an unknown seen matches only an unknown expected
  task automatic cmp_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic report_and_stop();
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // one edge: advance the model on what was sampled, then compare
  task automatic tick();
    bit ps, sel, wr;
    logic [1:0] low;
    logic [WIDE_LANES-1:0] we;
    @(posedge clk);
    #1;
    ps = !processor_address_strobe_n && !chip_select_primary_n;
    sel = !chip_select_primary_n && chip_select_depth_high && !chip_select_depth_low_n;
    wr = !global_write_n || (!byte_write_gate_n && !(&byte_lane_select_n));
    if (sys_rst) begin
      cyc = 0; // reset ends any burst
    end else if (!clk_en) begin
      cyc = cyc; // frozen: the model holds as the design does
    end else if (asleep) begin
      cyc = 0;
    end else if (ps || !controller_address_strobe_n) begin
      cyc = !sel ? 0 : (!ps && wr) ? 2 : 1;
      base = addr_in;
      n = 2'h0;
    end else if (cyc != 0) begin
      n = n + 2'(!burst_step_n);
      cyc = wr ? 2 : 1;
    end
    low = burst_order_sel ? base[1:0] ^ n : base[1:0] + n;
    we = (cyc != 2) ? '0 : !global_write_n ? '1 : ~byte_lane_select_n;
    cmp_val("lane_we", we, core_lane_we);
    cmp_val("dq_oe", cyc == 1 && !output_enable_n, dq_oe);
    if (cyc != 0) cmp_val("addr", {base[WIDE_ADDR_WIDTH-1:2], low}, core_addr);
    if (cyc == 2) cmp_val("wdata", dq_in, core_wdata);
    if (cyc == 1) cmp_val("rdata", mm[{base[3:2], low}], dq_out);
    for (int i = 0; i < WIDE_LANES; i++) begin
      if (we[i]) mm[{base[3:2], low}][i*LANE_BITS +: LANE_BITS] = dq_in[i*LANE_BITS +: LANE_BITS];
    end
    // output enable moved mid-cycle must reach the drive at once
    #1 output_enable_n = !output_enable_n;
    #1 cmp_val("dq_oe_async", cyc == 1 && !output_enable_n, dq_oe);
  endtask : tick

  // deselect cycle: controller strobe with primary select off ends a burst
  task automatic idle();
    chip_select_primary_n = 1;
    processor_address_strobe_n = 1;
    controller_address_strobe_n = 0;
  endtask : idle

  // random bus cycle, biased so starts and bursts are frequent
  task automatic rnd();
    bit o;
    o = 1'($urandom);
    chip_select_primary_n = ($urandom % 6) == 0;
    chip_select_depth_high = ($urandom % 6) != 0;
    chip_select_depth_low_n = ($urandom % 6) == 0;
    processor_address_strobe_n = ($urandom % 4) != 0;
    controller_address_strobe_n = ($urandom % 3) != 0;
    burst_step_n = 1'($urandom);
    global_write_n = ($urandom % 3) != 0;
    byte_write_gate_n = 1'($urandom);
    byte_lane_select_n = 4'($urandom);
    addr_in = 18'($urandom);
    dq_in = 36'({$urandom, $urandom});
    // enable is raised whenever write data is offered
    output_enable_n = o | !global_write_n | (!byte_write_gate_n & !(&byte_lane_select_n));
  endtask : rnd

  // bounded wait on the power state; running out is a mismatch
  task automatic wait_snooze(input logic v);
    for (int k = 0; k < 12 && snoozing !== v; k++) tick();
    cmp_val("snoozing", v, snoozing);
    if (snoozing !== v) report_and_stop();
  endtask : wait_snooze

  initial begin
    void'($urandom(17));
    for (int i = 0; i < 16; i++) mm[i] = '0;
    sys_rst = 1;
    clk_en = 1;
    sleep_request = 0;
    burst_order_sel = 1;
    rnd();
    idle();
    repeat (10) @(posedge clk);
    #1;
    cmp_val("rst_oe", 1'b0, dq_oe);
    cmp_val("rst_we", '0, core_lane_we);
    cmp_val("rst_snooze", 1'b0, snoozing);
    #2;
    sys_rst = 0;
    // both burst orders, each after a settling gap of deselects
    for (int m = 0; m < 2; m++) begin
      burst_order_sel = m[0];
      repeat (4) tick();
      repeat (400) begin
        rnd();
        tick();
      end
      idle();
    end
    // snooze: strobes offered while asleep must do nothing
    sleep_request = 1;
    asleep = 1;
    wait_snooze(1'b1);
    chip_select_primary_n = 0;
    chip_select_depth_high = 1;
    chip_select_depth_low_n = 0;
    processor_address_strobe_n = 0;
    repeat (3) tick();
    idle();
    sleep_request = 0;
    wait_snooze(1'b0);
    tick();
    asleep = 0;
    // frozen enable: random requests must leave every state untouched
    clk_en = 0;
    repeat (3) begin
      rnd();
      tick();
    end
    clk_en = 1;
    // reset in mid-run, then random bus cycles from the first edge after release
    sys_rst = 1;
    repeat (2) tick();
    sys_rst = 0;
    repeat (60) begin
      rnd();
      tick();
    end
    report_and_stop();
  end
endmodule : tb_sync_burst_sram_cycle_control
